// [verilog/ipt_pkg.sv]
// package of constants and types for the interval and pulse timers
package ipt_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int SPAN_W_DEF  = 16;  // elapsed and limit width
  localparam int NBLK_DEF    = 8;   // number of live-value source blocks
  localparam int TB_N        = 4;   // number of timebase tick lines
  localparam int TB_SEL_W    = 2;   // timebase select width
  localparam int CYC_W       = 4;   // cycle tally width

  // ---------------------------------------------------------------
  // cycle tally range of the edge-triggered relay
  // ---------------------------------------------------------------
  localparam logic [CYC_W-1:0] CYC_MIN = 4'h1;  // fewest cycles
  localparam logic [CYC_W-1:0] CYC_MAX = 4'h9;  // most cycles

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic       OUT_RST   = 1'b0;  // every relay output low
  localparam logic       PREV_RST  = 1'b0;  // edge detectors see low
  localparam logic       PHASE_RST = 1'b1;  // generator starts high

  // ---------------------------------------------------------------
  // edge-triggered relay sequence states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IPT_EDG_IDLE = 2'b00,  // waiting for a launch edge
    IPT_EDG_LOW  = 2'b01,  // timing the low phase, output low
    IPT_EDG_HIGH = 2'b10   // timing the high phase, output high
  } ipt_edg_state_t;

endpackage

// [verilog/ipt_param_sel.sv]
// timing parameter source: constant or live value of another block
`timescale 1ns/100ps
`default_nettype none

module ipt_param_sel
  import ipt_pkg::*;
#(
  parameter int SPAN_W = SPAN_W_DEF,
  parameter int NBLK   = NBLK_DEF,
  parameter int BLK_W  = $clog2(NBLK)
) (
  input  wire logic [SPAN_W-1:0]      const_val,
  input  wire logic                   use_live,
  input  wire logic [BLK_W-1:0]       blk_num,
  input  wire logic [NBLK*SPAN_W-1:0] live_vals,
  output logic      [SPAN_W-1:0]      limit
);

  // ---------------------------------------------------------------
  // source select
  // ---------------------------------------------------------------
  // pick the live result of the numbered block, else the constant
  always_comb begin
    limit = const_val;
    if (use_live && (int'(blk_num) < NBLK)) begin
      limit = live_vals[blk_num*SPAN_W +: SPAN_W];
    end
  end

endmodule

`default_nettype wire

// [verilog/ipt_timers.sv]
// interval relay, edge-triggered pulse-train relay and pulse generator
//
// Function
// - launch rise sets output, restarts elapsed
// - output drops when elapsed equals pulse span
// - launch fall ends the pulse early
// - per-function retentivity, keep or not keep
// - non-retentive state cleared after power failure
// - limits may come from another block
// - launch rise: low phase, then high
// - repeat low-high cycle tally times, 1..9
// - retrigger before end restarts the sequence
// - wipe clears elapsed and forces output low
// - generator runs only while gate on
// - generator alternates high and low phases
// - polarity flip only while gated on
`timescale 1ns/100ps
`default_nettype none

module ipt_timers
  import ipt_pkg::*;
#(
  parameter int SPAN_W = SPAN_W_DEF,       // elapsed and limit width
  parameter int NBLK   = NBLK_DEF,         // live-value source blocks
  parameter int BLK_W  = $clog2(NBLK)      // block number width
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // shared timebase, power events and live values
  input  wire logic [TB_N-1:0]        tick_vec,
  input  wire logic                   pwr_restore,
  input  wire logic [NBLK*SPAN_W-1:0] live_vals,
  // interval relay
  input  wire logic                   launch_in_ivl,
  input  wire logic [TB_SEL_W-1:0]    tick_sel_ivl,
  input  wire logic                   retain_ivl,
  input  wire logic [SPAN_W-1:0]      pulse_span,
  input  wire logic                   pulse_span_live,
  input  wire logic [BLK_W-1:0]       pulse_span_blk,
  output logic                        relay_output_ivl,
  output logic      [SPAN_W-1:0]      elapsed_span_ivl,
  // edge-triggered pulse-train relay
  input  wire logic                   launch_in_edg,
  input  wire logic                   wipe_input,
  input  wire logic [TB_SEL_W-1:0]    tick_sel_edg,
  input  wire logic                   retain_edg,
  input  wire logic [CYC_W-1:0]       cycle_tally,
  input  wire logic [SPAN_W-1:0]      high_phase_len_edg,
  input  wire logic                   high_live_edg,
  input  wire logic [BLK_W-1:0]       high_blk_edg,
  input  wire logic [SPAN_W-1:0]      low_phase_len_edg,
  input  wire logic                   low_live_edg,
  input  wire logic [BLK_W-1:0]       low_blk_edg,
  output logic                        relay_output_edg,
  output logic      [SPAN_W-1:0]      elapsed_span_edg,
  output logic      [CYC_W-1:0]       cycles_done_edg,
  // pulse generator
  input  wire logic                   gate_on,
  input  wire logic                   flip_out_polarity,
  input  wire logic [TB_SEL_W-1:0]    tick_sel_gen,
  input  wire logic                   retain_gen,
  input  wire logic [SPAN_W-1:0]      high_phase_len_gen,
  input  wire logic                   high_live_gen,
  input  wire logic [BLK_W-1:0]       high_blk_gen,
  input  wire logic [SPAN_W-1:0]      low_phase_len_gen,
  input  wire logic                   low_live_gen,
  input  wire logic [BLK_W-1:0]       low_blk_gen,
  output logic                        relay_output_gen,
  output logic      [SPAN_W-1:0]      elapsed_span_gen
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // select one tick line of the shared timebase
  function automatic logic pick_tick(input logic [TB_N-1:0]     tv,
                                     input logic [TB_SEL_W-1:0] sel);
    pick_tick = tv[sel];
  endfunction

  // one timebase step of an elapsed counter
  function automatic logic [SPAN_W-1:0] step(input logic [SPAN_W-1:0] v,
                                             input logic              tk);
    step = tk ? SPAN_W'(v + 1'b1) : v;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 ivl_prev;   // launch level last cycle
    logic                 ivl_out;    // interval relay output
    logic [SPAN_W-1:0]    ivl_span;   // interval elapsed time
    logic                 edg_prev;   // launch level last cycle
    ipt_edg_state_t       edg_st;     // pulse-train sequence state
    logic                 edg_out;    // pulse-train output
    logic [SPAN_W-1:0]    edg_span;   // pulse-train elapsed time
    logic [CYC_W-1:0]     edg_cyc;    // completed cycles
    logic                 gen_phase;  // 1 = high phase
    logic                 gen_out;    // generator output
    logic [SPAN_W-1:0]    gen_span;   // generator elapsed time
  } ipt_state_t;

  ipt_state_t state_r;    // registered state
  ipt_state_t state_nxt;  // next state

  logic [SPAN_W-1:0] lim_ivl;       // resolved pulse span
  logic [SPAN_W-1:0] lim_hi_edg;    // resolved high phase, relay
  logic [SPAN_W-1:0] lim_lo_edg;    // resolved low phase, relay
  logic [SPAN_W-1:0] lim_hi_gen;    // resolved high phase, generator
  logic [SPAN_W-1:0] lim_lo_gen;    // resolved low phase, generator
  logic [CYC_W-1:0]  tally_eff;     // cycle tally clamped to range
  logic              tk_ivl;        // interval timebase tick
  logic              tk_edg;        // relay timebase tick
  logic              tk_gen;        // generator timebase tick

  // ---------------------------------------------------------------
  // parameter sources
  // ---------------------------------------------------------------
  ipt_param_sel #(.SPAN_W(SPAN_W), .NBLK(NBLK), .BLK_W(BLK_W)) u_sel_ivl (
    .const_val (pulse_span),
    .use_live  (pulse_span_live),
    .blk_num   (pulse_span_blk),
    .live_vals (live_vals),
    .limit     (lim_ivl)
  );

  ipt_param_sel #(.SPAN_W(SPAN_W), .NBLK(NBLK), .BLK_W(BLK_W)) u_sel_hi_edg (
    .const_val (high_phase_len_edg),
    .use_live  (high_live_edg),
    .blk_num   (high_blk_edg),
    .live_vals (live_vals),
    .limit     (lim_hi_edg)
  );

  ipt_param_sel #(.SPAN_W(SPAN_W), .NBLK(NBLK), .BLK_W(BLK_W)) u_sel_lo_edg (
    .const_val (low_phase_len_edg),
    .use_live  (low_live_edg),
    .blk_num   (low_blk_edg),
    .live_vals (live_vals),
    .limit     (lim_lo_edg)
  );

  ipt_param_sel #(.SPAN_W(SPAN_W), .NBLK(NBLK), .BLK_W(BLK_W)) u_sel_hi_gen (
    .const_val (high_phase_len_gen),
    .use_live  (high_live_gen),
    .blk_num   (high_blk_gen),
    .live_vals (live_vals),
    .limit     (lim_hi_gen)
  );

  ipt_param_sel #(.SPAN_W(SPAN_W), .NBLK(NBLK), .BLK_W(BLK_W)) u_sel_lo_gen (
    .const_val (low_phase_len_gen),
    .use_live  (low_live_gen),
    .blk_num   (low_blk_gen),
    .live_vals (live_vals),
    .limit     (lim_lo_gen)
  );

  // ---------------------------------------------------------------
  // timebase and tally
  // ---------------------------------------------------------------
  // each function picks its own timebase; tally held to 1..9
  always_comb begin
    tk_ivl    = pick_tick(tick_vec, tick_sel_ivl);
    tk_edg    = pick_tick(tick_vec, tick_sel_edg);
    tk_gen    = pick_tick(tick_vec, tick_sel_gen);
    tally_eff = cycle_tally;
    if (cycle_tally < CYC_MIN) begin
      tally_eff = CYC_MIN;
    end else if (cycle_tally > CYC_MAX) begin
      tally_eff = CYC_MAX;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt          = state_r;
    state_nxt.ivl_prev = launch_in_ivl;
    state_nxt.edg_prev = launch_in_edg;

    // interval relay: edges first, then expiry, then counting
    if (launch_in_ivl && !state_r.ivl_prev) begin
      state_nxt.ivl_out  = 1'b1;
      state_nxt.ivl_span = '0;
    end else if (!launch_in_ivl && state_r.ivl_prev) begin
      state_nxt.ivl_out  = 1'b0;
    end else if (state_r.ivl_out) begin
      if (state_r.ivl_span == lim_ivl) begin
        state_nxt.ivl_out  = 1'b0;
      end else begin
        state_nxt.ivl_span = step(state_r.ivl_span, tk_ivl);
      end
    end

    // pulse-train relay: wipe beats a launch edge in the same cycle
    if (wipe_input) begin
      state_nxt.edg_st   = IPT_EDG_IDLE;
      state_nxt.edg_out  = 1'b0;
      state_nxt.edg_span = '0;
      state_nxt.edg_cyc  = '0;
    end else if (launch_in_edg && !state_r.edg_prev) begin
      state_nxt.edg_st   = IPT_EDG_LOW;
      state_nxt.edg_out  = 1'b0;
      state_nxt.edg_span = '0;
      state_nxt.edg_cyc  = '0;
    end else begin
      case (state_r.edg_st)
        IPT_EDG_LOW: begin
          if (state_r.edg_span == lim_lo_edg) begin
            state_nxt.edg_st   = IPT_EDG_HIGH;
            state_nxt.edg_out  = 1'b1;
            state_nxt.edg_span = '0;
          end else begin
            state_nxt.edg_span = step(state_r.edg_span, tk_edg);
          end
        end
        IPT_EDG_HIGH: begin
          if (state_r.edg_span == lim_hi_edg) begin
            state_nxt.edg_out  = 1'b0;
            state_nxt.edg_span = '0;
            state_nxt.edg_cyc  = CYC_W'(state_r.edg_cyc + 1'b1);
            if (CYC_W'(state_r.edg_cyc + 1'b1) == tally_eff) begin
              state_nxt.edg_st = IPT_EDG_IDLE;
            end else begin
              state_nxt.edg_st = IPT_EDG_LOW;
            end
          end else begin
            state_nxt.edg_span = step(state_r.edg_span, tk_edg);
          end
        end
        default: begin
          state_nxt.edg_st  = IPT_EDG_IDLE;   // idle holds last span
          state_nxt.edg_out = 1'b0;
        end
      endcase
    end

    // pulse generator: stopped and low while gated off
    if (!gate_on) begin
      state_nxt.gen_phase = PHASE_RST;
      state_nxt.gen_span  = '0;
      state_nxt.gen_out   = 1'b0;
    end else begin
      if (state_r.gen_phase && (state_r.gen_span == lim_hi_gen)) begin
        state_nxt.gen_phase = 1'b0;
        state_nxt.gen_span  = '0;
      end else if (!state_r.gen_phase && (state_r.gen_span == lim_lo_gen)) begin
        state_nxt.gen_phase = 1'b1;
        state_nxt.gen_span  = '0;
      end else begin
        state_nxt.gen_span = step(state_r.gen_span, tk_gen);
      end
      state_nxt.gen_out = state_nxt.gen_phase ^ flip_out_polarity;
    end

    // power restored: functions without retentivity lose their state
    if (pwr_restore) begin
      if (!retain_ivl) begin
        state_nxt.ivl_out  = OUT_RST;
        state_nxt.ivl_span = '0;
      end
      if (!retain_edg) begin
        state_nxt.edg_st   = IPT_EDG_IDLE;
        state_nxt.edg_out  = OUT_RST;
        state_nxt.edg_span = '0;
        state_nxt.edg_cyc  = '0;
      end
      if (!retain_gen) begin
        state_nxt.gen_phase = PHASE_RST;
        state_nxt.gen_out   = gate_on ? ~flip_out_polarity : OUT_RST;
        state_nxt.gen_span  = '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r.ivl_prev  <= PREV_RST;
      state_r.ivl_out   <= OUT_RST;
      state_r.ivl_span  <= '0;
      state_r.edg_prev  <= PREV_RST;
      state_r.edg_st    <= IPT_EDG_IDLE;
      state_r.edg_out   <= OUT_RST;
      state_r.edg_span  <= '0;
      state_r.edg_cyc   <= '0;
      state_r.gen_phase <= PHASE_RST;
      state_r.gen_out   <= OUT_RST;
      state_r.gen_span  <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  assign relay_output_ivl = state_r.ivl_out;
  assign elapsed_span_ivl = state_r.ivl_span;
  assign relay_output_edg = state_r.edg_out;
  assign elapsed_span_edg = state_r.edg_span;
  assign cycles_done_edg  = state_r.edg_cyc;
  assign relay_output_gen = state_r.gen_out;
  assign elapsed_span_gen = state_r.gen_span;

endmodule

`default_nettype wire

// [sim/ipt_tick_src.sv]
// tick source model that drives the shared timebase lines
`timescale 1ns/100ps
`default_nettype none
module ipt_tick_src
  import ipt_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  output logic      [TB_N-1:0] tick_vec
);
  logic [1:0] div_r;  // free running divider
  // divider restarts with reset
  always_ff @(posedge ref_clk) begin
    div_r <= rst_n ? div_r + 2'h1 : 2'h0;
  end
  // line 0 every cycle, 1 every 2nd, 2 every 4th, 3 stalled
  assign tick_vec = {1'b0, div_r == 2'h3, div_r[0], 1'b1};
endmodule
`default_nettype wire

// [sim/ipt_timers_assertions.sv]
// concurrent checks on the timer ports
`timescale 1ns/100ps
`default_nettype none
module ipt_timers_chk
  import ipt_pkg::*;
#(
  parameter int SPAN_W = SPAN_W_DEF  // elapsed and limit width
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [TB_N-1:0]   tick_vec,
  input wire logic              pwr_restore,
  input wire logic              launch_in_ivl,
  input wire logic [1:0]        tick_sel_ivl,
  input wire logic              retain_ivl,
  input wire logic [SPAN_W-1:0] pulse_span,
  input wire logic              pulse_span_live,
  input wire logic              relay_output_ivl,
  input wire logic [SPAN_W-1:0] elapsed_span_ivl,
  input wire logic              launch_in_edg,
  input wire logic              wipe_input,
  input wire logic              relay_output_edg,
  input wire logic [SPAN_W-1:0] elapsed_span_edg,
  input wire logic [CYC_W-1:0]  cycles_done_edg,
  input wire logic              gate_on,
  input wire logic              flip_out_polarity,
  input wire logic              relay_output_gen,
  input wire logic [SPAN_W-1:0] elapsed_span_gen
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ivl_rise; $rose(launch_in_ivl) && !pwr_restore; endsequence
  sequence s_edg_rise; $rose(launch_in_edg) && !wipe_input && !pwr_restore; endsequence
  sequence s_gen_on; $rose(gate_on) && !pwr_restore; endsequence
  property p_ivl_set; s_ivl_rise |=> relay_output_ivl && elapsed_span_ivl == '0; endproperty
  a_ivl_set: assert property (p_ivl_set) else $error("interval not set");
  property p_ivl_end; relay_output_ivl && !pulse_span_live && elapsed_span_ivl == pulse_span
    && !$rose(launch_in_ivl) |=> !relay_output_ivl; endproperty
  a_ivl_end: assert property (p_ivl_end) else $error("interval not ended");
  property p_ivl_fall; $fell(launch_in_ivl) |=> !relay_output_ivl; endproperty
  a_ivl_fall: assert property (p_ivl_fall) else $error("early fall ignored");
  property p_ivl_pwr; pwr_restore && !retain_ivl |=> !relay_output_ivl
    && elapsed_span_ivl == '0; endproperty
  a_ivl_pwr: assert property (p_ivl_pwr) else $error("power clear missed");
  property p_ivl_step; relay_output_ivl && launch_in_ivl && !$rose(launch_in_ivl)
    && tick_sel_ivl == 2'h0 && tick_vec[0] && !pulse_span_live && !pwr_restore
    && elapsed_span_ivl != pulse_span |=> elapsed_span_ivl == $past(elapsed_span_ivl) + 1'b1;
  endproperty
  a_ivl_step: assert property (p_ivl_step) else $error("span did not step");
  property p_edg_rise; s_edg_rise |=> !relay_output_edg && elapsed_span_edg == '0
    && cycles_done_edg == '0; endproperty
  a_edg_rise: assert property (p_edg_rise) else $error("no restart");
  property p_edg_wipe; wipe_input |=> !relay_output_edg && elapsed_span_edg == '0; endproperty
  a_edg_wipe: assert property (p_edg_wipe) else $error("wipe ignored");
  property p_edg_tally; cycles_done_edg <= CYC_MAX; endproperty
  a_edg_tally: assert property (p_edg_tally) else $error("too many cycles");
  property p_gen_off; !gate_on |=> !relay_output_gen && elapsed_span_gen == '0; endproperty
  a_gen_off: assert property (p_gen_off) else $error("generator not stopped");
  property p_gen_on; s_gen_on |=> relay_output_gen == !$past(flip_out_polarity); endproperty
  a_gen_on: assert property (p_gen_on) else $error("bad start level");
endmodule
bind ipt_timers ipt_timers_chk #(.SPAN_W(SPAN_W)) chk_u (.ref_clk, .rst_n, .tick_vec,
  .pwr_restore, .launch_in_ivl, .tick_sel_ivl, .retain_ivl, .pulse_span, .pulse_span_live,
  .relay_output_ivl, .elapsed_span_ivl, .launch_in_edg, .wipe_input, .relay_output_edg,
  .elapsed_span_edg, .cycles_done_edg, .gate_on, .flip_out_polarity, .relay_output_gen,
  .elapsed_span_gen);
`default_nettype wire

// [sim/ipt_timers_tb.sv]
// self-checking bench for the interval and pulse timers
`timescale 1ns/100ps
`default_nettype none
module ipt_timers_tb;
  import ipt_pkg::*;
  typedef struct { int k; int a; int b; int c; int e; } ipt_row_t;  // kind, args, high count
  // kind 0 interval (c = tick line), 1 pulse train, 2 interval with live limit
  ipt_row_t rows [9] = '{'{0,2,0,0,3}, '{0,0,0,0,1}, '{0,5,0,0,6}, '{0,2,0,3,99},
    '{2,3,0,0,4}, '{1,1,1,2,4}, '{1,0,2,0,3}, '{1,1,0,12,9}, '{1,2,1,9,18}};
  logic ref_clk, rst_n = 1'b0, pwr_restore = 1'b0;  // clock, reset, power event
  logic launch_in_ivl = 1'b0, retain_ivl = 1'b0, pulse_span_live = 1'b0;
  logic launch_in_edg = 1'b0, wipe_input = 1'b0, retain_edg = 1'b0;
  logic gate_on = 1'b0, flip_out_polarity = 1'b0, retain_gen = 1'b0;
  logic high_live_edg = 1'b0, low_live_edg = 1'b0, high_live_gen = 1'b0, low_live_gen = 1'b0;
  logic [1:0] tick_sel_ivl = 2'h0, tick_sel_edg = 2'h0, tick_sel_gen = 2'h0;
  logic [2:0] pulse_span_blk = 3'h2, high_blk_edg = 3'h0, low_blk_edg = 3'h0;
  logic [2:0] high_blk_gen = 3'h0, low_blk_gen = 3'h0;
  logic [3:0] cycle_tally = 4'h1, cycles_done_edg;
  logic [15:0] pulse_span = 16'h0000, high_phase_len_edg = 16'h0000;
  logic [15:0] low_phase_len_edg = 16'h0000, high_phase_len_gen = 16'h0000;
  logic [15:0] low_phase_len_gen = 16'h0000, elapsed_span_ivl, elapsed_span_edg;
  logic [15:0] elapsed_span_gen;  // generator elapsed ticks
  logic [127:0] live_vals = 128'h0;  // live results of other blocks
  logic [3:0] tick_vec;  // timebase from the tick model
  logic relay_output_ivl, relay_output_edg, relay_output_gen, last;
  int mismatches = 0, checks_done = 0, hi;
  ipt_timers dut_u (.ref_clk, .rst_n, .tick_vec, .pwr_restore, .live_vals, .launch_in_ivl,
    .tick_sel_ivl, .retain_ivl, .pulse_span, .pulse_span_live, .pulse_span_blk,
    .relay_output_ivl, .elapsed_span_ivl, .launch_in_edg, .wipe_input, .tick_sel_edg,
    .retain_edg, .cycle_tally, .high_phase_len_edg, .high_live_edg, .high_blk_edg,
    .low_phase_len_edg, .low_live_edg, .low_blk_edg, .relay_output_edg, .elapsed_span_edg,
    .cycles_done_edg, .gate_on, .flip_out_polarity, .tick_sel_gen, .retain_gen,
    .high_phase_len_gen, .high_live_gen, .high_blk_gen, .low_phase_len_gen, .low_live_gen,
    .low_blk_gen, .relay_output_gen, .elapsed_span_gen);
  ipt_tick_src tick_u (.ref_clk, .rst_n, .tick_vec);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one comparison, counted
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  // apply one row, count high cycles of its output over 100 cycles
  task automatic run_row(input ipt_row_t r, output int n);
    n = 0;
    if (r.k == 1) begin
      low_phase_len_edg <= 16'(r.a);
      high_phase_len_edg <= 16'(r.b);
      cycle_tally <= 4'(r.c);
      launch_in_edg <= 1'b1;
    end else begin
      pulse_span <= (r.k == 2) ? 16'h0028 : 16'(r.a);
      live_vals[32 +: 16] <= 16'(r.a);
      pulse_span_live <= (r.k == 2);
      tick_sel_ivl <= 2'(r.c);
      launch_in_ivl <= 1'b1;
    end
    repeat (100) begin
      @(negedge ref_clk);
      if (((r.k == 1) ? relay_output_edg : relay_output_ivl) === 1'b1) n++;
    end
    @(posedge ref_clk);
    launch_in_ivl <= 1'b0;
    launch_in_edg <= 1'b0;
    pulse_span_live <= 1'b0;
    cyc(5);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    cyc(20000);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    check(!relay_output_ivl && !relay_output_edg && !relay_output_gen, "reset levels");
    cyc(1);
    foreach (rows[i]) begin
      run_row(rows[i], hi);
      check(hi == rows[i].e, "row high count");
    end
    // early fall ends the interval pulse
    pulse_span <= 16'h0032;
    launch_in_ivl <= 1'b1;
    cyc(5);
    launch_in_ivl <= 1'b0;
    cyc(2);
    @(negedge ref_clk);
    check(relay_output_ivl === 1'b0, "early fall");
    // power restore, retentive then not
    cyc(1);
    launch_in_ivl <= 1'b1;
    retain_ivl <= 1'b1;
    cyc(5);
    pwr_restore <= 1'b1;
    cyc(1);
    pwr_restore <= 1'b0;
    cyc(2);
    @(negedge ref_clk);
    check(relay_output_ivl === 1'b1, "retained state lost");
    cyc(1);
    retain_ivl <= 1'b0;
    pwr_restore <= 1'b1;
    cyc(1);
    pwr_restore <= 1'b0;
    cyc(1);
    @(negedge ref_clk);
    check(!relay_output_ivl && elapsed_span_ivl === 16'h0000, "power clear");
    // retrigger in the high phase
    cyc(1);
    launch_in_ivl <= 1'b0;
    low_phase_len_edg <= 16'h0003;
    high_phase_len_edg <= 16'h0003;
    cycle_tally <= 4'h1;
    launch_in_edg <= 1'b1;
    cyc(7);
    launch_in_edg <= 1'b0;
    cyc(1);
    launch_in_edg <= 1'b1;
    @(negedge ref_clk);
    check(relay_output_edg === 1'b1, "high phase");
    cyc(2);
    @(negedge ref_clk);
    check(!relay_output_edg && cycles_done_edg === 4'h0, "no restart");
    hi = 0;
    repeat (30) begin
      @(negedge ref_clk);
      if (relay_output_edg === 1'b1) hi++;
    end
    check(hi == 4, "restart pulse");
    // wipe in a long high phase
    cyc(1);
    launch_in_edg <= 1'b0;
    low_phase_len_edg <= 16'h0000;
    high_phase_len_edg <= 16'h0014;
    cyc(1);
    launch_in_edg <= 1'b1;
    cyc(6);
    wipe_input <= 1'b1;
    cyc(2);
    @(negedge ref_clk);
    check(!relay_output_edg && elapsed_span_edg === 16'h0000, "wipe");
    cyc(1);
    wipe_input <= 1'b0;
    // generator start level, polarity and gating
    high_phase_len_gen <= 16'h0032;
    low_phase_len_gen <= 16'h0032;
    gate_on <= 1'b1;
    cyc(3);
    @(negedge ref_clk);
    check(relay_output_gen === 1'b1, "start high");
    cyc(1);
    flip_out_polarity <= 1'b1;
    cyc(2);
    @(negedge ref_clk);
    check(relay_output_gen === 1'b0, "flip");
    cyc(1);
    gate_on <= 1'b0;
    cyc(2);
    @(negedge ref_clk);
    check(relay_output_gen === 1'b0 && elapsed_span_gen === 16'h0000, "gated off");
    cyc(1);
    flip_out_polarity <= 1'b0;
    high_phase_len_gen <= 16'h0002;
    low_phase_len_gen <= 16'h0002;
    gate_on <= 1'b1;
    hi = 0;
    last = 1'b0;
    repeat (40) begin
      @(negedge ref_clk);
      if (relay_output_gen !== last) hi++;
      last = relay_output_gen;
    end
    check(hi >= 8, "generator toggles");
    // power restore mid low phase: non-retentive generator restarts high
    cyc(1);
    pwr_restore <= 1'b1;
    cyc(1);
    pwr_restore <= 1'b0;
    @(negedge ref_clk);
    check(relay_output_gen === 1'b1 && elapsed_span_gen === 16'h0000, "gen power");
    report_and_stop();
  end
endmodule
`default_nettype wire
